// ==== hdl/sdm_pkg.sv ====
// Operation
// - Each data pin carries two words per cycle
// - Read data leaves on an output-only bus
// - Write data arrives on an input-only bus
// - Read data aligned to free-running output clock
// - Commands registered on command clock rising edge
// - Write data registered on both strobe edges
// - Accesses are bursts of 2, 4 or 8
// - Eight independently addressed banks
// - Refresh row comes from internal per-bank counter
// - Commands decoded only while chip select low
// - Masked write words are discarded
// - Bank select names the bank of each read, write and refresh command; mode ignores it
`default_nettype none
package sdm_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 20;
  localparam int BANK_W = 3;
  localparam int BANKS = 8;
  localparam int COL_W = 4;
  localparam int ROW_W = 13;
  localparam int IDX_W = BANK_W + COL_W;
  localparam int MEM_WORDS = BANKS * (2 ** COL_W);
  localparam int MODE_SIZE_LSB = 0;

  localparam logic [1:0] SIZE_2 = 2'h0;
  localparam logic [1:0] SIZE_4 = 2'h1;
  localparam logic [1:0] SIZE_8 = 2'h2;
  localparam logic [1:0] RESET_SIZE = SIZE_2;
  localparam logic [3:0] WORDS_2 = 4'h2;
  localparam logic [3:0] WORDS_4 = 4'h4;
  localparam logic [3:0] WORDS_8 = 4'h8;
  localparam logic [3:0] WORDS_PER_CYCLE = 4'h2;
  localparam logic [COL_W-1:0] COL_ONE = 4'h1;
  localparam logic [COL_W-1:0] COL_TWO = 4'h2;

  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_REFRESH = 2'h2;
  localparam logic [1:0] KIND_MODE = 2'h3;

  localparam int CLOCK_PERIOD_NS = 10;
  localparam int LINK_DIV = 4;
  localparam int LINK_PERIOD_NS = LINK_DIV * CLOCK_PERIOD_NS;
  localparam logic [1:0] PH_RESET = 2'h3;
  localparam logic [1:0] PH_RISE_SLOT = 2'h2;
  localparam logic [1:0] PH_FALL_SLOT = 2'h0;

  function automatic logic [3:0] sdm_burst_words(input logic [1:0] code);
    unique case (code)
      SIZE_4: return WORDS_4;
      SIZE_8: return WORDS_8;
      default: return WORDS_2;
    endcase
  endfunction : sdm_burst_words
endpackage : sdm_pkg
`default_nettype wire

// ==== hdl/sdm_link_if.sv ====
`default_nettype none
interface sdm_link_if
  import sdm_pkg::*;
  ();
  logic command_clk;
  logic chip_select_n;
  logic write_enable_n;
  logic refresh_n;
  logic [ADDR_W-1:0] addr;
  logic [BANK_W-1:0] bank_select;
  logic write_data_strobe;
  logic [DATA_W-1:0] write_data;
  logic write_word_mask;
  logic read_clk;
  logic [DATA_W-1:0] read_data;
  logic read_valid;

  modport mem (
    input command_clk, chip_select_n, write_enable_n, refresh_n, addr, bank_select,
    input write_data_strobe, write_data, write_word_mask,
    output read_clk, read_data, read_valid
  );
  modport ctl (
    output command_clk, chip_select_n, write_enable_n, refresh_n, addr, bank_select,
    output write_data_strobe, write_data, write_word_mask,
    input read_clk, read_data, read_valid
  );
endinterface : sdm_link_if
`default_nettype wire

// ==== hdl/sdm_ctl_end.sv ====
`default_nettype none
module sdm_ctl_end
  import sdm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  sdm_link_if.ctl link,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_kind,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [BANK_W-1:0] i_req_bank,
  output logic o_req_ready,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wmask,
  output logic o_wdata_take,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rdata_valid
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CMD = 3'h2,
    ST_BURST = 3'h4
  } sdm_ctl_st_e;

  typedef struct packed {
    sdm_ctl_st_e st;
    logic [1:0] ph;
    logic lclk;
    logic ready;
    logic [1:0] kind;
    logic [ADDR_W-1:0] req_addr;
    logic [BANK_W-1:0] req_bank;
    logic [1:0] size;
    logic [3:0] left;
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [ADDR_W-1:0] pin_addr;
    logic [BANK_W-1:0] pin_bank;
    logic [DATA_W-1:0] wd;
    logic wm;
    logic take;
    logic rc1;
    logic rc2;
    logic rc3;
    logic [DATA_W-1:0] rd1;
    logic [DATA_W-1:0] rd2;
    logic rv1;
    logic rv2;
    logic pend;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } sdm_ctl_s;

  sdm_ctl_s s_reg;
  sdm_ctl_s s_next;
  logic slot;

  always_comb begin
    s_next = s_reg;
    s_next.ph = s_reg.ph + 2'h1;
    s_next.lclk = ~s_next.ph[1];
    s_next.take = 1'b0;
    s_next.rvalid = 1'b0;
    // Words alternate rise/fall slots; even count left means a rise word
    slot = (s_reg.ph == PH_RISE_SLOT && !s_reg.left[0]) ||
           (s_reg.ph == PH_FALL_SLOT && s_reg.left[0]);
    // Pins change mid low phase so they are stable at the rising edge
    // Only chip select drops; the stale code leans on the device's gate
    if (s_reg.ph == PH_RISE_SLOT) begin
      s_next.cs_n = 1'b1;
    end
    unique case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.ready && i_req_valid) begin
          s_next.ready = 1'b0;
          s_next.kind = i_req_kind;
          s_next.req_addr = i_req_addr;
          s_next.req_bank = i_req_bank;
          s_next.st = ST_CMD;
        end
      end
      ST_CMD: begin
        if (s_reg.ph == PH_RISE_SLOT) begin
          s_next.cs_n = 1'b0;
          s_next.we_n = ~(s_reg.kind == KIND_WRITE || s_reg.kind == KIND_MODE);
          s_next.ref_n = ~(s_reg.kind == KIND_REFRESH || s_reg.kind == KIND_MODE);
          s_next.pin_addr = s_reg.req_addr;
          s_next.pin_bank = s_reg.req_bank;
          s_next.left = sdm_burst_words(s_reg.size);
          if (s_reg.kind == KIND_READ || s_reg.kind == KIND_WRITE) begin
            s_next.st = ST_BURST;
          end else begin
            s_next.st = ST_IDLE;
            s_next.ready = 1'b1;
          end
          if (s_reg.kind == KIND_MODE) begin
            s_next.size = s_reg.req_addr[MODE_SIZE_LSB +: 2];
          end
        end
      end
      ST_BURST: begin
        if (slot) begin
          if (s_reg.kind == KIND_WRITE) begin
            s_next.wd = i_wdata;
            s_next.wm = i_wmask;
            s_next.take = 1'b1;
          end
          s_next.left = s_reg.left - 4'h1;
          if (s_reg.left == 4'h1) begin
            s_next.st = ST_IDLE;
            s_next.ready = 1'b1;
          end
        end
      end
    endcase
    // Oversampled capture; each read word lasts two of our cycles
    s_next.rc1 = link.read_clk;
    s_next.rc2 = s_reg.rc1;
    s_next.rc3 = s_reg.rc2;
    s_next.rd1 = link.read_data;
    s_next.rd2 = s_reg.rd1;
    s_next.rv1 = link.read_valid;
    s_next.rv2 = s_reg.rv1;
    s_next.pend = s_reg.rc2 ^ s_reg.rc3;
    if (s_reg.pend) begin
      s_next.rdata = s_reg.rd2;
      s_next.rvalid = s_reg.rv2;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.ph <= PH_RESET;
      s_reg.ready <= 1'b1;
      s_reg.size <= RESET_SIZE;
      s_reg.cs_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.ref_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.command_clk = s_reg.lclk;
  assign link.write_data_strobe = s_reg.lclk;
  assign link.chip_select_n = s_reg.cs_n;
  assign link.write_enable_n = s_reg.we_n;
  assign link.refresh_n = s_reg.ref_n;
  assign link.addr = s_reg.pin_addr;
  assign link.bank_select = s_reg.pin_bank;
  assign link.write_data = s_reg.wd;
  assign link.write_word_mask = s_reg.wm;
  assign o_req_ready = s_reg.ready;
  assign o_wdata_take = s_reg.take;
  assign o_rdata = s_reg.rdata;
  assign o_rdata_valid = s_reg.rvalid;
endmodule : sdm_ctl_end
`default_nettype wire

// ==== hdl/sdm_mem_end.sv ====
`default_nettype none
module sdm_mem_end
  import sdm_pkg::*;
(
  input wire logic i_rst_n,
  sdm_link_if.mem link,
  output logic [1:0] o_burst_size,
  output logic [BANK_W-1:0] o_refresh_bank,
  output logic [ROW_W-1:0] o_refresh_row,
  output logic o_refresh_toggle
);
  typedef struct packed {
    logic [1:0] size;
    logic w_lag;
    logic w_on;
    logic [3:0] w_left;
    logic [COL_W-1:0] w_ptr;
    logic [BANK_W-1:0] w_bank;
    logic r_on;
    logic [3:0] r_left;
    logic [COL_W-1:0] r_ptr;
    logic [BANK_W-1:0] r_bank;
    logic [DATA_W-1:0] q_rise;
    logic [DATA_W-1:0] q_late;
    logic valid;
    logic t_rise;
    logic [BANKS-1:0][ROW_W-1:0] rows;
    logic [BANK_W-1:0] ref_bank;
    logic [ROW_W-1:0] ref_row;
    logic ref_tgl;
  } sdm_mem_s;

  sdm_mem_s s_reg;
  sdm_mem_s s_next;

  // Falling-edge half of the output double-rate path
  logic [DATA_W-1:0] q_fall_reg;
  logic t_fall_reg;

  // Write words caught on each strobe edge
  logic [DATA_W-1:0] wr_rise_data_reg;
  logic wr_rise_mask_reg;
  logic [DATA_W-1:0] wr_fall_data_reg;
  logic wr_fall_mask_reg;

  // Storage array: all banks, a small column space each
  logic [DATA_W-1:0] mem [MEM_WORDS];

  logic cmd_write;
  logic cmd_read;
  logic cmd_refresh;
  logic cmd_mode;
  logic mem_we_rise;
  logic mem_we_fall;
  logic [DATA_W-1:0] rd_first;
  logic [DATA_W-1:0] rd_second;

  function automatic logic [IDX_W-1:0] sdm_word_index(
    input logic [BANK_W-1:0] bank,
    input logic [COL_W-1:0] col
  );
    return {bank, col};
  endfunction : sdm_word_index

  // One chip-select gate for every command code
  function automatic logic sdm_cmd_hit(
    input logic cs_n,
    input logic we_n,
    input logic ref_n,
    input logic code_we_n,
    input logic code_ref_n
  );
    return !cs_n && (we_n == code_we_n) && (ref_n == code_ref_n);
  endfunction : sdm_cmd_hit

  // Strobe is launched by the same flop as the command clock, so the
  // two are edge aligned and the captured words are stable by the
  // next command clock rising edge.
  always_ff @(posedge link.write_data_strobe or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_rise_data_reg <= '0;
      wr_rise_mask_reg <= 1'b1;
    end else begin
      wr_rise_data_reg <= link.write_data;
      wr_rise_mask_reg <= link.write_word_mask;
    end
  end

  always_ff @(negedge link.write_data_strobe or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_fall_data_reg <= '0;
      wr_fall_mask_reg <= 1'b1;
    end else begin
      wr_fall_data_reg <= link.write_data;
      wr_fall_mask_reg <= link.write_word_mask;
    end
  end

  always_comb begin
    s_next = s_reg;
    mem_we_rise = 1'b0;
    mem_we_fall = 1'b0;
    rd_first = '0;
    rd_second = '0;
    // Decoder gated by chip select; running bursts go on regardless
    cmd_write = sdm_cmd_hit(link.chip_select_n, link.write_enable_n, link.refresh_n,
                            1'h0, 1'h1);
    cmd_read = sdm_cmd_hit(link.chip_select_n, link.write_enable_n, link.refresh_n,
                           1'h1, 1'h1);
    cmd_refresh = sdm_cmd_hit(link.chip_select_n, link.write_enable_n, link.refresh_n,
                              1'h1, 1'h0);
    cmd_mode = sdm_cmd_hit(link.chip_select_n, link.write_enable_n, link.refresh_n,
                           1'h0, 1'h0);

    // Write data trails its command by one cycle
    if (s_reg.w_lag) begin
      s_next.w_lag = 1'b0;
      s_next.w_on = 1'b1;
    end
    if (s_reg.w_on) begin
      mem_we_rise = !wr_rise_mask_reg;
      mem_we_fall = !wr_fall_mask_reg;
      s_next.w_ptr = s_reg.w_ptr + COL_TWO;
      s_next.w_left = s_reg.w_left - WORDS_PER_CYCLE;
      if (s_reg.w_left == WORDS_PER_CYCLE) begin
        s_next.w_on = 1'b0;
      end
    end

    // Two words leave per cycle: one at each command clock edge
    s_next.valid = 1'b0;
    if (s_reg.r_on) begin
      rd_first = mem[sdm_word_index(s_reg.r_bank, s_reg.r_ptr)];
      rd_second = mem[sdm_word_index(s_reg.r_bank, s_reg.r_ptr + COL_ONE)];
      s_next.valid = 1'b1;
      s_next.r_ptr = s_reg.r_ptr + COL_TWO;
      s_next.r_left = s_reg.r_left - WORDS_PER_CYCLE;
      if (s_reg.r_left == WORDS_PER_CYCLE) begin
        s_next.r_on = 1'b0;
      end
    end
    // Output is q_rise ^ q_fall; each half cancels the other's old value
    s_next.q_rise = rd_first ^ q_fall_reg;
    s_next.q_late = rd_second;
    s_next.t_rise = ~s_reg.t_rise;

    // A new command overrides any burst of the same kind in flight
    if (cmd_write) begin
      s_next.w_lag = 1'b1;
      s_next.w_on = 1'b0;
      s_next.w_left = sdm_burst_words(s_reg.size);
      s_next.w_ptr = link.addr[COL_W-1:0];
      s_next.w_bank = link.bank_select;
    end
    if (cmd_read) begin
      s_next.r_on = 1'b1;
      s_next.r_left = sdm_burst_words(s_reg.size);
      s_next.r_ptr = link.addr[COL_W-1:0];
      s_next.r_bank = link.bank_select;
    end
    if (cmd_refresh) begin
      // Address pins are ignored; only the bank matters
      // Row counters wrap freely; spacing refreshes is the controller's job
      s_next.ref_row = s_reg.rows[link.bank_select];
      s_next.rows[link.bank_select] = s_reg.rows[link.bank_select] + 13'h1;
      s_next.ref_bank = link.bank_select;
      s_next.ref_tgl = ~s_reg.ref_tgl;
    end
    // New size applies to the next command; a running burst keeps its count
    if (cmd_mode) begin
      s_next.size = link.addr[MODE_SIZE_LSB +: 2];
    end
  end

  // Reset release is not resynchronised; release it while the link idles
  always_ff @(posedge link.command_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.size <= RESET_SIZE;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(negedge link.command_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_fall_reg <= '0;
      t_fall_reg <= 1'b0;
    end else begin
      q_fall_reg <= s_reg.q_late ^ s_reg.q_rise;
      t_fall_reg <= ~t_fall_reg;
    end
  end

  // No reset on storage; contents are undefined until written
  always_ff @(posedge link.command_clk) begin
    if (mem_we_rise) begin
      mem[sdm_word_index(s_reg.w_bank, s_reg.w_ptr)] <= wr_rise_data_reg;
    end
    if (mem_we_fall) begin
      mem[sdm_word_index(s_reg.w_bank, s_reg.w_ptr + COL_ONE)] <= wr_fall_data_reg;
    end
  end

  // Clock and data share edges so the far end sees them aligned
  assign link.read_clk = s_reg.t_rise ^ t_fall_reg;
  assign link.read_data = s_reg.q_rise ^ q_fall_reg;
  assign link.read_valid = s_reg.valid;
  assign o_burst_size = s_reg.size;
  assign o_refresh_bank = s_reg.ref_bank;
  assign o_refresh_row = s_reg.ref_row;
  assign o_refresh_toggle = s_reg.ref_tgl;
endmodule : sdm_mem_end
`default_nettype wire

// ==== dv/sdm_link_props.sv ====
`default_nettype none
module sdm_link_props (
  input wire logic i_rst_n,
  input wire logic command_clk,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic refresh_n,
  input wire logic write_data_strobe,
  input wire logic read_clk,
  input wire logic read_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  property p_read_clk_low_at_rise;
    @(posedge command_clk) disable iff (!i_rst_n) !read_clk;
  endproperty
  a_read_clk_low_at_rise: assert property (p_read_clk_low_at_rise)
    else $error("read clock high before command clock rise");

  property p_read_clk_high_at_fall;
    @(negedge command_clk) disable iff (!i_rst_n) read_clk;
  endproperty
  a_read_clk_high_at_fall: assert property (p_read_clk_high_at_fall)
    else $error("read clock low before command clock fall");

  property p_strobe_low_at_rise;
    @(posedge command_clk) disable iff (!i_rst_n) !write_data_strobe;
  endproperty
  a_strobe_low_at_rise: assert property (p_strobe_low_at_rise)
    else $error("write strobe out of phase at rise");

  property p_strobe_high_at_fall;
    @(negedge command_clk) disable iff (!i_rst_n) write_data_strobe;
  endproperty
  a_strobe_high_at_fall: assert property (p_strobe_high_at_fall)
    else $error("write strobe out of phase at fall");

  // Sampled values lag by one edge, so the burst shows two rises later
  property p_read_starts_burst;
    @(posedge command_clk) disable iff (!i_rst_n)
      (!chip_select_n && write_enable_n && refresh_n) |-> ##2 read_valid;
  endproperty
  a_read_starts_burst: assert property (p_read_starts_burst)
    else $error("read command without read burst");

  property p_valid_needs_command;
    @(posedge command_clk) disable iff (!i_rst_n)
      $rose(read_valid) |-> $past(!chip_select_n && write_enable_n && refresh_n, 2);
  endproperty
  a_valid_needs_command: assert property (p_valid_needs_command)
    else $error("read burst without selected read command");

  property p_burst_at_most_eight;
    @(posedge command_clk) disable iff (!i_rst_n) read_valid [*4] |=> !read_valid;
  endproperty
  a_burst_at_most_eight: assert property (p_burst_at_most_eight)
    else $error("read burst longer than eight words");

  property p_access_single_cycle;
    @(posedge command_clk) disable iff (!i_rst_n)
      (!chip_select_n && refresh_n) |=> chip_select_n;
  endproperty
  a_access_single_cycle: assert property (p_access_single_cycle)
    else $error("access command held past one link cycle");
endmodule : sdm_link_props
`default_nettype wire

// ==== dv/sio_ddr_burst_memory_port_tb.sv ====
`default_nettype none
module sio_ddr_burst_memory_port_tb
  import sdm_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock;
  logic i_rst_n;
  logic mem_rst_n;
  logic req_valid;
  logic [1:0] req_kind;
  logic [ADDR_W-1:0] req_addr;
  logic [BANK_W-1:0] req_bank;
  logic [DATA_W-1:0] wdata;
  logic wmask;
  logic req_ready;
  logic wdata_take;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid;
  logic [1:0] burst_size;
  logic [BANK_W-1:0] refresh_bank;
  logic [ROW_W-1:0] refresh_row;
  logic refresh_toggle;
  logic tog_exp;
  logic [DATA_W-1:0] exp_mem [BANKS][2**COL_W];
  logic [ROW_W-1:0] row_exp [BANKS];
  int n_mismatch;
  int comparisons;
  int cur_bl;

  sdm_link_if u_sdm_link_if ();
  sdm_ctl_end u_sdm_ctl_end (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(u_sdm_link_if),
    .i_req_valid(req_valid), .i_req_kind(req_kind), .i_req_addr(req_addr),
    .i_req_bank(req_bank), .o_req_ready(req_ready), .i_wdata(wdata), .i_wmask(wmask),
    .o_wdata_take(wdata_take), .o_rdata(rdata), .o_rdata_valid(rdata_valid));
  sdm_mem_end u_sdm_mem_end (.i_rst_n(mem_rst_n), .link(u_sdm_link_if),
    .o_burst_size(burst_size), .o_refresh_bank(refresh_bank),
    .o_refresh_row(refresh_row), .o_refresh_toggle(refresh_toggle));
  sdm_link_props u_sdm_link_props (.i_rst_n(mem_rst_n),
    .command_clk(u_sdm_link_if.command_clk), .chip_select_n(u_sdm_link_if.chip_select_n),
    .write_enable_n(u_sdm_link_if.write_enable_n), .refresh_n(u_sdm_link_if.refresh_n),
    .write_data_strobe(u_sdm_link_if.write_data_strobe),
    .read_clk(u_sdm_link_if.read_clk), .read_valid(u_sdm_link_if.read_valid));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(inout int n);
    @(negedge i_clock);
    n++;
    if (n > 2000) begin
      n_mismatch++;
      final_report();
    end
  endtask : tick

  task automatic settle();
    int n;
    n = 0;
    while (req_ready !== 1'b1) tick(n);
    // Leave time for the slow link domain to show its outputs
    repeat (12) @(negedge i_clock);
  endtask : settle

  task automatic req(input logic [1:0] k, input logic [ADDR_W-1:0] a,
                     input logic [BANK_W-1:0] b);
    int n;
    n = 0;
    @(negedge i_clock);
    while (req_ready !== 1'b1) tick(n);
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_bank = b;
    @(negedge i_clock);
    req_valid = 1'b0;
  endtask : req

  function automatic logic [DATA_W-1:0] mkword(input int s, input int i);
    return DATA_W'(s * 64 + i + 37);
  endfunction : mkword

  task automatic set_size(input logic [1:0] code);
    req(KIND_MODE, ADDR_W'(code), 3'h0);
    settle();
    check(32'(burst_size), 32'(code));
    cur_bl = 2 << code;
  endtask : set_size

  task automatic do_write(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
                          input int s, input logic [7:0] mk);
    int i;
    int n;
    logic [COL_W-1:0] col;
    i = 0;
    n = 0;
    wdata = mkword(s, 0);
    wmask = mk[0];
    req(KIND_WRITE, ADDR_W'(c), b);
    while (i < cur_bl) begin
      if (wdata_take === 1'b1) begin
        col = c + COL_W'(i);
        if (!wmask) exp_mem[b][col] = wdata;
        i++;
        wdata = mkword(s, i);
        wmask = mk[i[2:0]];
      end
      if (i < cur_bl) tick(n);
    end
  endtask : do_write

  task automatic do_read(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c);
    int i;
    int n;
    logic [COL_W-1:0] col;
    i = 0;
    n = 0;
    req(KIND_READ, ADDR_W'(c), b);
    while (i < cur_bl) begin
      if (rdata_valid === 1'b1) begin
        col = c + COL_W'(i);
        check(32'(rdata), 32'(exp_mem[b][col]));
        i++;
      end
      tick(n);
    end
    // Stray words after the burst would mean a wrong length
    repeat (40) begin
      @(negedge i_clock);
      if (rdata_valid !== 1'b0) i++;
    end
    check(32'(i), 32'(cur_bl));
  endtask : do_read

  task automatic t_refresh();
    logic [BANK_W-1:0] bs [3] = '{3'h3, 3'h7, 3'h3};
    foreach (bs[j]) begin
      req(KIND_REFRESH, 20'h5a5a5, bs[j]);
      settle();
      tog_exp = ~tog_exp;
      check(32'(refresh_bank), 32'(bs[j]));
      check(32'(refresh_row), 32'(row_exp[bs[j]]));
      check(32'(refresh_toggle), 32'(tog_exp));
      row_exp[bs[j]]++;
    end
  endtask : t_refresh

  task automatic t_sizes();
    for (int k = 0; k < 3; k++) begin
      set_size(2'(k));
      // Column 14 makes the longer bursts wrap inside the bank
      do_write(3'(k), 4'he, k, 8'h00);
      do_write(3'(k), 4'he, k + 10, 8'ha5);
      do_read(3'(k), 4'he);
    end
  endtask : t_sizes

  task automatic t_banks();
    for (int k = 0; k < 3; k++) do_write(3'(k * 3 + 1), 4'h4, k + 20, 8'h00);
    for (int k = 0; k < 3; k++) do_read(3'(k * 3 + 1), 4'h4);
  endtask : t_banks

  initial begin
    i_rst_n = 1'b0;
    mem_rst_n = 1'b0;
    req_valid = 1'b0;
    req_kind = 2'h0;
    req_addr = '0;
    req_bank = '0;
    wdata = '0;
    wmask = 1'b0;
    tog_exp = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cur_bl = 2;
    foreach (row_exp[j]) row_exp[j] = '0;
    repeat (12) @(negedge i_clock);
    i_rst_n = 1'b1;
    // Release just after a link clock fall, while the controller idles
    repeat (11) @(negedge i_clock);
    mem_rst_n = 1'b1;
    settle();
    check(32'(burst_size), 32'h0);
    check(32'(refresh_row), 32'h0);
    check(32'(refresh_toggle), 32'h0);
    t_refresh();
    t_sizes();
    t_banks();
    final_report();
  end
endmodule : sio_ddr_burst_memory_port_tb
`default_nettype wire
